// [core/rsss_cfg.svh]
// offsets, field positions, reset values and opcode patterns of the executor
//----------------------------------------------------------------------------
// What this block does
// RL1: rotate right through carry, carry into bit7
// RL2: rotate dest bit 0 accumulator, 1 file
// RL3: rotate decode 001100, only carry changes
// RL4: file address seven bits, dest bit 0/1
// RL5: opcode 0003 enters power-down, stops oscillator
// RL6: power-down clears PWRDN and sets TMOUT, arithmetic flags kept
// RL7: literal minus accumulator into accumulator, flags
// RL8: subtract carry set means no borrow
// RL9: subtract zero flag set on zero result
// RL10: file minus accumulator, dest 0 accumulator
// RL11: file minus accumulator, dest 1 file
// RL12: nibble exchange decode 001110, no flags
// RL13: nibble exchange dest 0 accumulator, 1 file
// RL14: digit carry set when low nibble no borrow
//----------------------------------------------------------------------------
`ifndef RSSS_CFG_SVH
`define RSSS_CFG_SVH

// apb byte offsets
`define RSSS_OFF_INSTR   12'h000
`define RSSS_OFF_ACC     12'h004
`define RSSS_OFF_STATUS  12'h008
`define RSSS_OFF_FADDR   12'h00C
`define RSSS_OFF_FDATA   12'h010

// status bit positions
`define RSSS_ST_C        0
`define RSSS_ST_DIGC     1
`define RSSS_ST_Z        2
`define RSSS_ST_PWRDN    3
`define RSSS_ST_TMOUT    4
`define RSSS_ST_BAD      5

// reset values
`define RSSS_RST_STATUS  8'h18
`define RSSS_RST_ACC     8'h00

// opcode patterns, upper six bits unless whole word
`define RSSS_PAT_ROTR    6'h0C
`define RSSS_PAT_LITSUB  6'h1D
`define RSSS_PAT_FILESUB 6'h02
`define RSSS_PAT_NIBX    6'h0E
`define RSSS_PAT_SLEEP   14'h0003

`endif

// [core/rsss_pkg.sv]
// types and the opcode decoder of the executor
package rsss_pkg;
`include "rsss_cfg.svh"

   // operation selected by the decoder
   typedef enum logic [2:0]
   {
      rsss_op_none,
      rsss_op_rotr,
      rsss_op_sleep,
      rsss_op_litsub,
      rsss_op_filesub,
      rsss_op_nibx
   } rsss_op_t;

   // opcode to operation, used by datapath and checks
   function automatic rsss_op_t rsss_decode(input logic [13:0] opc);
      rsss_op_t op;
      op = rsss_op_none;
      if (opc == `RSSS_PAT_SLEEP)
         op = rsss_op_sleep;
      else if (opc[13:8] == `RSSS_PAT_ROTR)
         op = rsss_op_rotr;
      else if (opc[13:8] == `RSSS_PAT_LITSUB)
         op = rsss_op_litsub;
      else if (opc[13:8] == `RSSS_PAT_FILESUB)
         op = rsss_op_filesub;
      else if (opc[13:8] == `RSSS_PAT_NIBX)
         op = rsss_op_nibx;
      return op;
   endfunction
endpackage

// [core/rsss_alu.sv]
// combinational datapath for rotate, subtract and nibble exchange
module rsss_alu
   import rsss_pkg::*;
(
   input  rsss_op_t   op,         // decoded operation
   input  wire  logic [7:0] fval, // addressed file value
   input  wire  logic [7:0] acc,  // accumulator
   input  wire  logic [7:0] lit,  // literal field
   input  wire  logic       c_in, // current carry
   output logic [7:0] res,        // result byte
   output logic       c_out,      // new carry
   output logic       digc_out,   // new digit carry
   output logic       z_out       // new zero
);
   logic [7:0] minuend;  // literal or file value
   logic [8:0] diff;     // nine bits keep the borrow
   logic [4:0] ldiff;    // low nibble with borrow

   // datapath, one operation per cycle
   always_comb
   begin
      minuend = (op == rsss_op_litsub) ? lit : fval;
      diff    = {1'b0, minuend} - {1'b0, acc};
      ldiff   = {1'b0, minuend[3:0]} - {1'b0, acc[3:0]};
      res     = diff[7:0];
      c_out   = ~diff[8];              // RL8
      digc_out = ~ldiff[4];            // RL14
      z_out   = (diff[7:0] == 8'h00);  // RL9
      case (op)
         rsss_op_rotr:
         begin
            res   = {c_in, fval[7:1]}; // RL1
            c_out = fval[0];           // RL1
         end
         rsss_op_nibx:
            res = {fval[3:0], fval[7:4]}; // RL12
         default:
            ; // subtract result stands
      endcase
   end
endmodule

// [core/rsss_exec.sv]
// apb slave wrapping the executor: accumulator, status, file store
//
// Local design decisions: the register addresses and the APB interface to the registers.
module rsss_exec
   import rsss_pkg::*;
(
   input  wire  logic        pclk,     // core clock
   input  wire  logic        presetn,  // async reset, active low
   input  wire  logic        psel,     // apb select
   input  wire  logic        penable,  // apb access phase
   input  wire  logic        pwrite,   // apb direction
   input  wire  logic [11:0] paddr,    // apb byte address
   input  wire  logic [31:0] pwdata,   // apb write data
   input  wire  logic        wake,     // wake from power-down
   output logic [31:0] prdata,         // apb read data
   output logic        pready,         // apb ready
   output logic        pslverr,        // apb error, unmapped address
   output logic        osc_stop        // oscillator stopped
);
`include "rsss_cfg.svh"

   //-------------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------------
   logic [7:0]  acc_q,     acc_d;      // working accumulator
   logic [7:0]  status_q,  status_d;   // flags
   logic [13:0] lastop_q,  lastop_d;   // last executed opcode
   logic [6:0]  faddr_q,   faddr_d;    // software file pointer
   logic        asleep_q,  asleep_d;   // power-down state
   logic [31:0] prdata_q,  prdata_d;   // read data
   logic        pready_q,  pready_d;   // one wait state
   logic        pslverr_q, pslverr_d;  // error answer
   logic [7:0]  file_q [128];          // file registers
   logic        fwe;                   // file write enable
   logic [6:0]  fwa;                   // file write index
   logic [7:0]  fwd;                   // file write data

   //-------------------------------------------------------------------------
   // decode of the current transfer and opcode
   //-------------------------------------------------------------------------
   logic        wr_done;   // write completes this edge
   logic        exec;      // opcode executes this edge
   rsss_op_t    op;        // decoded operation
   logic        dbit;      // destination select
   logic [6:0]  fa;        // file address field
   logic [7:0]  lit;       // literal field
   logic [7:0]  fval;      // addressed file value
   logic [7:0]  res;       // alu result
   logic        c_n;       // alu carry
   logic        digc_n;    // alu digit carry
   logic        z_n;       // alu zero

   // register map hit, shared by write and error paths
   function automatic logic mapped(input logic [11:0] a);
      return (a == `RSSS_OFF_INSTR) || (a == `RSSS_OFF_ACC) ||
             (a == `RSSS_OFF_STATUS) || (a == `RSSS_OFF_FADDR) ||
             (a == `RSSS_OFF_FDATA);
   endfunction

   assign wr_done = psel && penable && pready_q && pwrite && mapped(paddr);
   // asleep core ignores opcodes until woken
   assign exec    = wr_done && (paddr == `RSSS_OFF_INSTR) && !asleep_q;
   assign op      = rsss_decode(pwdata[13:0]);
   assign dbit    = pwdata[7];          // RL4
   assign fa      = pwdata[6:0];        // RL4
   assign lit     = pwdata[7:0];
   assign fval    = file_q[fa];

   rsss_alu u_alu
   (
      .op     (op),
      .fval   (fval),
      .acc    (acc_q),
      .lit    (lit),
      .c_in   (status_q[`RSSS_ST_C]),
      .res    (res),
      .c_out  (c_n),
      .digc_out (digc_n),
      .z_out  (z_n)
   );

   //-------------------------------------------------------------------------
   // execution and software writes
   //-------------------------------------------------------------------------
   always_comb
   begin
      acc_d    = acc_q;
      status_d = status_q;
      lastop_d = lastop_q;
      faddr_d  = faddr_q;
      asleep_d = asleep_q && !wake;   // wake is a level from outside
      fwe      = 1'b0;
      fwa      = fa;
      fwd      = res;
      if (exec)
      begin
         lastop_d = pwdata[13:0];
         case (op)
            rsss_op_rotr:
            begin
               fwe = dbit;                        // RL2
               if (!dbit)
                  acc_d = res;                    // RL2
               status_d[`RSSS_ST_C] = c_n;        // RL3
            end
            rsss_op_sleep:
            begin
               asleep_d = 1'b1;                   // RL5
               status_d[`RSSS_ST_PWRDN] = 1'b0;   // RL6
               status_d[`RSSS_ST_TMOUT] = 1'b1;   // RL6
            end
            rsss_op_litsub:
            begin
               acc_d = res;                       // RL7
               status_d[`RSSS_ST_C]  = c_n;       // RL8
               status_d[`RSSS_ST_DIGC] = digc_n;  // RL14
               status_d[`RSSS_ST_Z]  = z_n;       // RL9
            end
            rsss_op_filesub:
            begin
               fwe = dbit;                        // RL11
               if (!dbit)
                  acc_d = res;                    // RL10
               status_d[`RSSS_ST_C]  = c_n;       // RL8
               status_d[`RSSS_ST_DIGC] = digc_n;  // RL14
               status_d[`RSSS_ST_Z]  = z_n;       // RL9
            end
            rsss_op_nibx:
            begin
               fwe = dbit;                        // RL13
               if (!dbit)
                  acc_d = res;                    // RL13
            end
            default:
               status_d[`RSSS_ST_BAD] = 1'b1;     // unknown opcode flagged
         endcase
      end
      else if (wr_done)
      begin
         case (paddr)
            `RSSS_OFF_ACC:
               acc_d = pwdata[7:0];
            `RSSS_OFF_STATUS:
            begin
               // arithmetic flags writable, power bits read-only
               status_d[`RSSS_ST_C]  = pwdata[`RSSS_ST_C];
               status_d[`RSSS_ST_DIGC] = pwdata[`RSSS_ST_DIGC];
               status_d[`RSSS_ST_Z]  = pwdata[`RSSS_ST_Z];
               if (pwdata[`RSSS_ST_BAD])
                  status_d[`RSSS_ST_BAD] = 1'b0;  // write one clears
            end
            `RSSS_OFF_FADDR:
               faddr_d = pwdata[6:0];
            `RSSS_OFF_FDATA:
            begin
               fwe = 1'b1;
               fwa = faddr_q;
               fwd = pwdata[7:0];
            end
            default:
               ; // instr write while asleep is dropped
         endcase
      end
   end

   //-------------------------------------------------------------------------
   // apb answer: one wait state so read data comes from a flop
   //-------------------------------------------------------------------------
   always_comb
   begin
      pready_d  = psel && penable && !pready_q;
      pslverr_d = pready_d && !mapped(paddr);
      prdata_d  = prdata_q;
      if (pready_d && !pwrite)
      begin
         case (paddr)
            `RSSS_OFF_INSTR:  prdata_d = {18'h0_0000, lastop_q};
            `RSSS_OFF_ACC:    prdata_d = {24'h00_0000, acc_q};
            `RSSS_OFF_STATUS: prdata_d = {24'h00_0000, 2'b00, status_q[5:0]};
            `RSSS_OFF_FADDR:  prdata_d = {25'h000_0000, faddr_q};
            `RSSS_OFF_FDATA:  prdata_d = {24'h00_0000, file_q[faddr_q]};
            default:          prdata_d = 32'h0000_0000;
         endcase
      end
   end

   //-------------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_q     <= `RSSS_RST_ACC;
         status_q  <= `RSSS_RST_STATUS;
         lastop_q  <= 14'h0000;
         faddr_q   <= 7'h00;
         asleep_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         acc_q     <= acc_d;
         status_q  <= status_d;
         lastop_q  <= lastop_d;
         faddr_q   <= faddr_d;
         asleep_q  <= asleep_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // file store has no reset, contents are software's business
   always_ff @(posedge pclk)
   begin
      if (fwe)
         file_q[fwa] <= fwd;
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign osc_stop = asleep_q;

   //-------------------------------------------------------------------------
   // checks
   //-------------------------------------------------------------------------
   logic [7:0] rot_exp;   // expected rotate result
   logic [7:0] minuend;   // subtract minuend
   logic [7:0] diff_exp;  // expected difference
   logic [7:0] nib_exp;   // expected swap
   logic       sub_op;    // either subtract
   assign rot_exp  = {status_q[`RSSS_ST_C], fval[7:1]};
   assign minuend  = (op == rsss_op_litsub) ? lit : fval;
   assign diff_exp = minuend - acc_q;
   assign nib_exp  = {fval[3:0], fval[7:4]};
   assign sub_op   = (op == rsss_op_litsub) || (op == rsss_op_filesub);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rotr_acc;
      exec && op == rsss_op_rotr && !dbit |=> acc_q == $past(rot_exp) &&
         status_q[`RSSS_ST_C] == $past(fval[0]);
   endproperty
   a_rotr_acc: assert property (p_rotr_acc) else $error("rotate to acc wrong"); // RL1

   property p_rotr_file;
      exec && op == rsss_op_rotr && dbit |=> acc_q == $past(acc_q) &&
         file_q[$past(fa)] == $past(rot_exp);
   endproperty
   a_rotr_file: assert property (p_rotr_file) else $error("rotate to file wrong"); // RL2

   property p_rotr_flags;
      exec && op == rsss_op_rotr |=> status_q[5:1] == $past(status_q[5:1]);
   endproperty
   a_rotr_flags: assert property (p_rotr_flags) else $error("rotate touched flags"); // RL3

   property p_sleep;
      exec && op == rsss_op_sleep |=> osc_stop && !status_q[`RSSS_ST_PWRDN] &&
         status_q[`RSSS_ST_TMOUT] && status_q[2:0] == $past(status_q[2:0]);
   endproperty
   a_sleep: assert property (p_sleep) else $error("power-down entry wrong"); // RL5

   // an opcode written while asleep must leave accumulator, status and last opcode alone
   property p_sleep_hold;
      osc_stop && !wake && wr_done && paddr == `RSSS_OFF_INSTR |=>
         acc_q == $past(acc_q) && status_q == $past(status_q) &&
         lastop_q == $past(lastop_q);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("exec while asleep"); // RL6

   property p_litsub;
      exec && op == rsss_op_litsub |=> acc_q == $past(diff_exp);
   endproperty
   a_litsub: assert property (p_litsub) else $error("literal subtract wrong"); // RL7

   property p_carry;
      exec && sub_op |=> status_q[`RSSS_ST_C] == ($past(minuend) >= $past(acc_q));
   endproperty
   a_carry: assert property (p_carry) else $error("subtract carry wrong"); // RL8

   property p_zero;
      exec && sub_op |=> status_q[`RSSS_ST_Z] == ($past(diff_exp) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("subtract zero wrong"); // RL9

   property p_filesub_acc;
      exec && op == rsss_op_filesub && !dbit |=> acc_q == $past(diff_exp);
   endproperty
   a_filesub_acc: assert property (p_filesub_acc) else $error("file sub acc wrong"); // RL10

   property p_filesub_file;
      exec && op == rsss_op_filesub && dbit |=> acc_q == $past(acc_q) &&
         file_q[$past(fa)] == $past(diff_exp);
   endproperty
   a_filesub_file: assert property (p_filesub_file) else $error("file sub wrong"); // RL11

   property p_nibx;
      exec && op == rsss_op_nibx |=> status_q == $past(status_q) &&
         (($past(dbit) && file_q[$past(fa)] == $past(nib_exp)) ||
          (!$past(dbit) && acc_q == $past(nib_exp)));
   endproperty
   a_nibx: assert property (p_nibx) else $error("nibble exchange wrong"); // RL12

   property p_digc;
      exec && sub_op |=> status_q[`RSSS_ST_DIGC] ==
         ($past(minuend[3:0]) >= $past(acc_q[3:0]));
   endproperty
   a_digc: assert property (p_digc) else $error("digit carry wrong"); // RL14

   c_rotr:   cover property (exec && op == rsss_op_rotr);
   c_borrow: cover property (exec && sub_op ##1 !status_q[`RSSS_ST_C]);
   c_sleep:  cover property (exec && op == rsss_op_sleep ##[1:20] !osc_stop);
endmodule

// [test/rsss_exec_test.sv]
// self-checking bench for the rotate, subtract, exchange and power-down executor
`include "rsss_cfg.svh"

module rsss_exec_test;
   timeunit 1ns;
   timeprecision 1ns;

   //------------------------------------------------------------------------
   // signals and bookkeeping
   //------------------------------------------------------------------------
   logic        pclk;       // 20 mhz core clock
   logic        presetn;    // async reset, active low
   logic        psel;       // apb select
   logic        penable;    // apb access phase
   logic        pwrite;     // apb direction
   logic [11:0] paddr;      // apb byte address
   logic [31:0] pwdata;     // apb write data
   logic        wake;       // leave power-down
   logic [31:0] prdata;     // apb read data
   logic        pready;     // apb ready pulse
   logic        pslverr;    // apb error
   logic        osc_stop;   // oscillator stopped
   logic [31:0] rdat;       // data of the last transfer
   logic        rerr;       // error of the last transfer
   int          err_total;  // mismatches seen
   int          num_checks; // comparisons made

   // one executed opcode: state before it and state it must leave
   typedef struct packed
   {
      logic [13:0] opc;
      logic [7:0]  acc_i;
      logic [7:0]  file_i;
      logic [2:0]  flg_i;  // zero, digit carry, carry
      logic [7:0]  acc_o;
      logic [7:0]  file_o;
      logic [2:0]  flg_o;
   } rsss_row_t;

   // flags packed as status bits 2:0; addresses 0x00 and 0x7f are the edges
   rsss_row_t rows [13] = '{
      '{14'h0c25, 8'h11, 8'he6, 3'h6, 8'h73, 8'he6, 3'h6},
      '{14'h0cff, 8'h3c, 8'h01, 3'h1, 8'h3c, 8'h80, 3'h1},
      '{14'h0c00, 8'h55, 8'h03, 3'h0, 8'h01, 8'h03, 3'h1},
      '{14'h1d15, 8'h10, 8'h44, 3'h4, 8'h05, 8'h44, 3'h3},
      '{14'h1d10, 8'h10, 8'h44, 3'h0, 8'h00, 8'h44, 3'h7},
      '{14'h1d05, 8'h10, 8'h44, 3'h5, 8'hf5, 8'h44, 3'h2},
      '{14'h1d20, 8'h01, 8'h44, 3'h6, 8'h1f, 8'h44, 3'h1},
      '{14'h02a5, 8'h02, 8'h03, 3'h0, 8'h02, 8'h01, 3'h3},
      '{14'h02a5, 8'h02, 8'h02, 3'h0, 8'h02, 8'h00, 3'h7},
      '{14'h02a5, 8'h02, 8'h01, 3'h7, 8'h02, 8'hff, 3'h0},
      '{14'h0210, 8'h0f, 8'h50, 3'h6, 8'h41, 8'h50, 3'h1},
      '{14'h0e25, 8'h99, 8'ha5, 3'h5, 8'h5a, 8'ha5, 3'h5},
      '{14'h0eff, 8'h77, 8'h3c, 3'h2, 8'h77, 8'hc3, 3'h2}
   };

   rsss_exec dut
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .wake     (wake),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .osc_stop (osc_stop)
   );

   //------------------------------------------------------------------------
   // tasks
   //------------------------------------------------------------------------
   // verdict and end of run, also reached by the watchdog
   task automatic conclude();
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // single comparison point; case inequality so unknowns never match
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         err_total++;
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed wait count assumed, only a bound against a hang
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         err_total++;
         conclude();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // bounded wait for the oscillator-stop level, then compare it
   task automatic wait_osc(input logic v);
      int n;
      n = 0;
      do
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      while (osc_stop !== v && n < 8);
      chk("osc_stop", {31'h0, osc_stop}, {31'h0, v});
   endtask

   //------------------------------------------------------------------------
   // clock and watchdog
   //------------------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // the run needs well under a thousand cycles; twenty thousand means a hang
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      conclude();
   end

   //------------------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------------------
   initial
   begin
      err_total  = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      wake    = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // reset state
      apb(1'b0, `RSSS_OFF_STATUS, 32'h0000_0000);
      chk("status_rst", rdat, 32'h0000_0018);
      apb(1'b0, `RSSS_OFF_ACC, 32'h0000_0000);
      chk("acc_rst", rdat, 32'h0000_0000);
      // table of ordinary operations
      foreach (rows[i])
      begin
         apb(1'b1, `RSSS_OFF_FADDR, {25'h0, rows[i].opc[6:0]});
         apb(1'b1, `RSSS_OFF_FDATA, {24'h0, rows[i].file_i});
         apb(1'b1, `RSSS_OFF_ACC, {24'h0, rows[i].acc_i});
         apb(1'b1, `RSSS_OFF_STATUS, {29'h0, rows[i].flg_i});
         apb(1'b1, `RSSS_OFF_INSTR, {18'h0, rows[i].opc});
         apb(1'b0, `RSSS_OFF_ACC, 32'h0000_0000);
         chk("acc", rdat, {24'h0, rows[i].acc_o});
         apb(1'b0, `RSSS_OFF_FDATA, 32'h0000_0000);
         chk("file", rdat, {24'h0, rows[i].file_o});
         apb(1'b0, `RSSS_OFF_STATUS, 32'h0000_0000);
         chk("status", rdat, 32'h0000_0018 | {29'h0, rows[i].flg_o});
      end
      // unmapped address refused
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk("slverr", {31'h0, rerr}, 32'h0000_0001);
      chk("rdata_unmapped", rdat, 32'h0000_0000);
      // unknown opcode only raises the sticky bit, then cleared by writing one
      apb(1'b1, `RSSS_OFF_INSTR, 32'h0000_3fff);
      apb(1'b0, `RSSS_OFF_STATUS, 32'h0000_0000);
      chk("status_bad", rdat, 32'h0000_003a);
      apb(1'b1, `RSSS_OFF_STATUS, 32'h0000_0025);
      // power-down keeps arithmetic flags, clears powerdown_flag
      apb(1'b1, `RSSS_OFF_INSTR, 32'h0000_0003);
      wait_osc(1'b1);
      apb(1'b0, `RSSS_OFF_STATUS, 32'h0000_0000);
      chk("status_sleep", rdat, 32'h0000_0015);
      // an opcode written while asleep is dropped
      apb(1'b1, `RSSS_OFF_INSTR, 32'h0000_1d15);
      apb(1'b0, `RSSS_OFF_ACC, 32'h0000_0000);
      chk("acc_sleep", rdat, 32'h0000_0077);
      // wake ends power-down; status bits stay as the sleep left them
      @(posedge pclk);
      wake <= 1'b1;
      wait_osc(1'b0);
      @(posedge pclk);
      wake <= 1'b0;
      apb(1'b0, `RSSS_OFF_STATUS, 32'h0000_0000);
      chk("status_wake", rdat, 32'h0000_0015);
      // second reset in mid-sleep
      apb(1'b1, `RSSS_OFF_INSTR, 32'h0000_0003);
      wait_osc(1'b1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("osc_rst", {31'h0, osc_stop}, 32'h0000_0000);
      presetn <= 1'b1;
      apb(1'b0, `RSSS_OFF_STATUS, 32'h0000_0000);
      chk("status_rst2", rdat, 32'h0000_0018);
      conclude();
   end
endmodule
